//--- dioh_pkg.sv
// Package for the parallel digital I/O port controller: modes, command map, timing.
// Assumes a 40 MHz core clock; all counts derive from it.
package dioh_pkg;
  localparam int CLK_HZ = 40000000;
  // Times in their own units
  localparam int WR_SETUP_US = 1000;
  localparam int RD_RELEASE_US = 100;
  localparam int RD_LATCH_US = 150;
  localparam int STROBE_NS = 1000;
  localparam int WR_SETUP_CYC = (WR_SETUP_US * (CLK_HZ / 1000000));
  localparam int RD_RELEASE_CYC = (RD_RELEASE_US * (CLK_HZ / 1000000));
  localparam int RD_LATCH_CYC = (RD_LATCH_US * (CLK_HZ / 1000000));
  localparam int STROBE_CYC = (STROBE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // Register offsets
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_POL = 4'h1;
  localparam logic [3:0] ADDR_DIR = 4'h2;
  localparam logic [3:0] ADDR_WDATA = 4'h3;
  localparam logic [3:0] ADDR_CMD = 4'h4;
  localparam logic [3:0] ADDR_RDATA = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_BUILTIN = 4'h7;
  localparam logic [3:0] ADDR_BDIR = 4'h8;
  // Polarity field positions
  localparam int POL_CTL_BIT = 0;
  localparam int POL_FLG_BIT = 1;
  localparam int POL_DIR_BIT = 2;
  localparam int POL_DATA_BIT = 3;
  // Command field positions
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  // Status field positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_SCAN_OK_BIT = 1;
  localparam int ST_FIFO_FULL_BIT = 2;
  localparam int ST_RVALID_BIT = 3;
  // Reset values
  localparam logic [2:0] MODE_RESET = 3'h1;
  localparam logic [3:0] POL_RESET = 4'h0;
  typedef enum logic [2:0] {
    DIOH_MODE_STATIC = 3'h1,
    DIOH_MODE_READBACK = 3'h2,
    DIOH_MODE_RW_STROBE = 3'h3,
    DIOH_MODE_SPLIT_STROBE = 3'h4,
    DIOH_MODE_HANDSHAKE = 3'h5
  } dioh_mode_t;
  typedef enum logic [2:0] {
    DIOH_IDLE = 3'h0,
    DIOH_WR_SETUP = 3'h1,
    DIOH_WR_STROBE = 3'h2,
    DIOH_RD_RELEASE = 3'h3,
    DIOH_RD_LATCH = 3'h4,
    DIOH_RD_STROBE = 3'h5
  } dioh_state_t;
endpackage : dioh_pkg

//--- dioh_fifo.sv
// Small synchronous FIFO carrying write words towards the port engine.
// Assumes one clock; both sides use valid/ready.
`timescale 1ns/1ps
module dioh_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin
      $error("FIFO depth must be a power of two of at least 2");
    end
  end
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } dioh_fifo_st_t;
  dioh_fifo_st_t st_reg;
  dioh_fifo_st_t st_next;
  logic push;
  logic pop;
  // The count is one bit wider than the pointers so that full and empty differ
  assign in_ready_out = (st_reg.count != (AW+1)'(DEPTH));
  assign out_valid_out = (st_reg.count != '0);
  assign out_data_out = st_reg.mem[st_reg.rptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  always_comb
  begin
    st_next = st_reg;
    if (push)
    begin
      st_next.mem[st_reg.wptr] = in_data_in;
      st_next.wptr = st_reg.wptr + AW'(1);
    end
    if (pop)
    begin
      st_next.rptr = st_reg.rptr + AW'(1);
    end
    st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end
endmodule : dioh_fifo

//--- dioh_port.sv
// Parallel digital I/O port controller: flow-control modes 1 to 4 on one
// 32-bit module port plus a 4-bit built-in port without flow control.
// Assumes a plain register port with read data one cycle after the strobe.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module dioh_port
  import dioh_pkg::*;
#(
  parameter int WR_SETUP_CYCLES = WR_SETUP_CYC,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  input wire logic [31:0] DATA_IN,
  output logic [31:0] DATA_OUT,
  output logic [31:0] DATA_OE_OUT,
  output logic DIR_LINE_OUT,
  output logic PERIPHERAL_STROBE_LINE_OUT,
  input wire logic PERIPHERAL_FLAG_LINE_IN,
  input wire logic [3:0] BUILTIN_IN,
  output logic [3:0] BUILTIN_OUT,
  output logic [3:0] BUILTIN_OE_OUT,
  output logic SCAN_OK_OUT
);
  initial begin
    // The setup check below watches eight idle-drive cycles, so shorter counts are refused
    if (WR_SETUP_CYCLES < 8 || WR_SETUP_CYCLES > 65535)
    begin
      $error("WR_SETUP_CYCLES out of range");
    end
  end
  typedef struct packed {
    dioh_state_t state;
    logic [2:0] mode;
    logic [3:0] pol;
    logic [3:0] dir_out;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic rvalid;
    logic [15:0] cnt;
    logic drive;
    logic dir_lvl;
    logic ctl_lvl;
    logic [3:0] b_data;
    logic [3:0] b_dir;
    logic [3:0] b_pol;
    logic [31:0] rd_bus;
    logic [31:0] d_s1;
    logic [31:0] d_s2;
    logic [3:0] b_s1;
    logic [3:0] b_s2;
    logic f_s1;
    logic f_s2;
  } dioh_st_t;
  dioh_st_t st_reg;
  dioh_st_t st_next;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [31:0] fifo_out_data;
  logic wr_push;
  logic [31:0] data_pol;

  function automatic logic [31:0] dioh_group_mask(input logic [3:0] grp);
    logic [31:0] m;
    m = '0;
    for (int g = 0; g < 4; g++)
    begin
      m[g*8 +: 8] = {8{grp[g]}};
    end
    return m;
  endfunction : dioh_group_mask

  function automatic logic dioh_strobe_mode(input logic [2:0] md);
    return (md == DIOH_MODE_RW_STROBE) || (md == DIOH_MODE_SPLIT_STROBE)
      || (md == DIOH_MODE_HANDSHAKE);
  endfunction : dioh_strobe_mode

  assign wr_push = WR_IN && (ADDR_IN == ADDR_WDATA);
  assign fifo_out_ready = (st_reg.state == DIOH_IDLE) && (st_reg.dir_out != '0);
  assign data_pol = {32{st_reg.pol[POL_DATA_BIT]}};

  dioh_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(CORE_CLK_IN),
    .resetn_in(RESETN_IN),
    .in_valid_in(wr_push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(WDATA_IN),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data)
  );

  always_comb
  begin
    st_next = st_reg;
    st_next.d_s1 = DATA_IN;
    st_next.d_s2 = st_reg.d_s1;
    st_next.b_s1 = BUILTIN_IN;
    st_next.b_s2 = st_reg.b_s1;
    st_next.f_s1 = PERIPHERAL_FLAG_LINE_IN;
    st_next.f_s2 = st_reg.f_s1;
    st_next.rd_bus = '0;
    if (st_reg.cnt != '0)
    begin
      st_next.cnt = st_reg.cnt - 16'h0001;
    end
    if (WR_IN)
    begin
      case (ADDR_IN)
        ADDR_MODE:
        begin
          if (WDATA_IN[2:0] >= 3'h1 && WDATA_IN[2:0] <= 3'h5)
          begin
            st_next.mode = WDATA_IN[2:0];
          end
        end
        ADDR_POL: st_next.pol = WDATA_IN[3:0];
        ADDR_DIR: st_next.dir_out = WDATA_IN[3:0];
        ADDR_BUILTIN: st_next.b_data = WDATA_IN[3:0];
        ADDR_BDIR:
        begin
          st_next.b_dir = WDATA_IN[3:0];
          st_next.b_pol = WDATA_IN[7:4];
        end
        default:
        begin
        end
      endcase
    end
    if (RD_IN)
    begin
      case (ADDR_IN)
        ADDR_MODE: st_next.rd_bus = {29'h0, st_reg.mode};
        ADDR_POL: st_next.rd_bus = {28'h0, st_reg.pol};
        ADDR_DIR: st_next.rd_bus = {28'h0, st_reg.dir_out};
        ADDR_RDATA:
        begin
          st_next.rd_bus = st_reg.rdata;
          st_next.rvalid = 1'b0;
        end
        ADDR_STATUS:
        begin
          st_next.rd_bus[ST_BUSY_BIT] = (st_reg.state != DIOH_IDLE);
          st_next.rd_bus[ST_SCAN_OK_BIT] = !dioh_strobe_mode(st_reg.mode);
          st_next.rd_bus[ST_FIFO_FULL_BIT] = !fifo_in_ready;
          st_next.rd_bus[ST_RVALID_BIT] = st_reg.rvalid;
        end
        ADDR_BUILTIN:
        begin
          st_next.rd_bus = {28'h0, st_reg.b_s2 ^ st_reg.b_pol};
        end
        ADDR_BDIR: st_next.rd_bus = {24'h0, st_reg.b_pol, st_reg.b_dir};
        default: st_next.rd_bus = '0;
      endcase
    end
    case (st_reg.state)
      DIOH_IDLE:
      begin
        if (fifo_out_valid && fifo_out_ready)
        begin
          st_next.wdata = fifo_out_data;
          if (st_reg.mode == DIOH_MODE_SPLIT_STROBE)
          begin
            st_next.drive = 1'b1;
            st_next.dir_lvl = 1'b1;
            st_next.cnt = 16'(STROBE_CYC);
            st_next.state = DIOH_WR_STROBE;
          end
          else
          begin
            // Lines are let go until setup has passed, so a new word never shows early
            st_next.drive = 1'b0;
            st_next.dir_lvl = 1'b0;
            st_next.cnt = 16'(WR_SETUP_CYCLES);
            st_next.state = DIOH_WR_SETUP;
          end
        end
        else if (WR_IN && ADDR_IN == ADDR_CMD && WDATA_IN[CMD_READ_BIT])
        begin
          st_next.cnt = 16'(RD_RELEASE_CYC);
          st_next.state = DIOH_RD_RELEASE;
          if (st_reg.mode == DIOH_MODE_SPLIT_STROBE)
          begin
            st_next.ctl_lvl = 1'b1;
          end
        end
      end
      DIOH_WR_SETUP:
      begin
        if (st_reg.cnt == '0)
        begin
          st_next.drive = 1'b1;
          if (st_reg.mode == DIOH_MODE_RW_STROBE)
          begin
            st_next.ctl_lvl = 1'b1;
            st_next.cnt = 16'(STROBE_CYC);
            st_next.state = DIOH_WR_STROBE;
          end
          else
          begin
            st_next.state = DIOH_IDLE;
          end
        end
      end
      DIOH_WR_STROBE:
      begin
        if (st_reg.cnt == '0)
        begin
          st_next.ctl_lvl = 1'b0;
          if (st_reg.mode == DIOH_MODE_SPLIT_STROBE)
          begin
            st_next.dir_lvl = 1'b0;
          end
          st_next.state = DIOH_IDLE;
        end
      end
      DIOH_RD_RELEASE:
      begin
        if (st_reg.cnt == '0)
        begin
          if (st_reg.mode != DIOH_MODE_READBACK)
          begin
            st_next.drive = 1'b0;
            if (st_reg.mode != DIOH_MODE_SPLIT_STROBE)
            begin
              st_next.dir_lvl = 1'b1;
            end
          end
          st_next.cnt = 16'(RD_LATCH_CYC);
          st_next.state = DIOH_RD_LATCH;
        end
      end
      DIOH_RD_LATCH:
      begin
        if (st_reg.cnt == '0)
        begin
          // With drive held (mode 2) output bytes read back the written word; other bytes come from the pins with the data polarity
          st_next.rdata = st_reg.drive
            ? ((st_reg.wdata & dioh_group_mask(st_reg.dir_out))
              | ((st_reg.d_s2 ^ data_pol) & ~dioh_group_mask(st_reg.dir_out)))
            : (st_reg.d_s2 ^ data_pol);
          st_next.rvalid = 1'b1;
          if (st_reg.mode == DIOH_MODE_RW_STROBE)
          begin
            st_next.ctl_lvl = 1'b1;
            st_next.cnt = 16'(STROBE_CYC);
            st_next.state = DIOH_RD_STROBE;
          end
          else
          begin
            st_next.ctl_lvl = 1'b0;
            st_next.state = DIOH_IDLE;
          end
        end
      end
      DIOH_RD_STROBE:
      begin
        if (st_reg.cnt == '0)
        begin
          st_next.ctl_lvl = 1'b0;
          st_next.state = DIOH_IDLE;
        end
      end
      default: st_next.state = DIOH_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      st_reg <= '0;
      st_reg.mode <= MODE_RESET;
      st_reg.pol <= POL_RESET;
      st_reg.dir_lvl <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Module port drives only output groups while the engine holds the lines
  assign DATA_OUT = st_reg.wdata ^ data_pol;
  assign DATA_OE_OUT = st_reg.drive ? dioh_group_mask(st_reg.dir_out) : 32'h0;
  assign DIR_LINE_OUT = st_reg.dir_lvl ^ st_reg.pol[POL_DIR_BIT];
  assign PERIPHERAL_STROBE_LINE_OUT = st_reg.ctl_lvl ^ st_reg.pol[POL_CTL_BIT];
  assign BUILTIN_OUT = st_reg.b_data ^ st_reg.b_pol;
  assign BUILTIN_OE_OUT = st_reg.b_dir;
  assign SCAN_OK_OUT = !dioh_strobe_mode(st_reg.mode);
  assign RDATA_OUT = st_reg.rd_bus;

  // Static write drives data only after the direction setup time
  wr_setup_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    (st_reg.state == DIOH_IDLE && st_next.state == DIOH_WR_SETUP)
    |=> !st_reg.drive [*8]) else $error("data driven before setup elapsed");
  reset_mode_a: assert property (@(posedge CORE_CLK_IN)
    $rose(RESETN_IN) |-> st_reg.mode == MODE_RESET && st_reg.pol == POL_RESET)
    else $error("reset mode or polarity wrong");
  reset_input_a: assert property (@(posedge CORE_CLK_IN)
    $rose(RESETN_IN) |-> DATA_OE_OUT == 32'h0 && BUILTIN_OE_OUT == 4'h0)
    else $error("outputs enabled after reset");
  scan_ok_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    SCAN_OK_OUT == (st_reg.mode == 3'h1 || st_reg.mode == 3'h2))
    else $error("scan permission wrong for mode");
  group_dir_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    DATA_OE_OUT[7:0] == {8{DATA_OE_OUT[0]}} && DATA_OE_OUT[15:8] == {8{DATA_OE_OUT[8]}}
    && DATA_OE_OUT[23:16] == {8{DATA_OE_OUT[16]}} && DATA_OE_OUT[31:24] == {8{DATA_OE_OUT[24]}})
    else $error("mixed direction in a byte group");
  readback_drive_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    (st_reg.mode == 3'h2 && st_reg.state == DIOH_RD_RELEASE && st_reg.drive) |=> st_reg.drive)
    else $error("mode 2 read released the drivers");
  sequence rd_strobe_s;
    st_reg.state == DIOH_RD_LATCH && st_reg.cnt == '0 && st_reg.mode == 3'h3;
  endsequence
  rd_strobe_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    rd_strobe_s |=> st_reg.ctl_lvl && st_reg.rvalid) else $error("no read strobe");
  dir_pol_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    DIR_LINE_OUT != (st_reg.dir_lvl == st_reg.pol[POL_DIR_BIT]))
    else $error("direction polarity not applied");
  split_wr_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    (st_reg.mode == 3'h4 && st_reg.state == DIOH_WR_STROBE) |-> st_reg.dir_lvl && st_reg.drive)
    else $error("mode 4 write strobe missing");
  // Strobe modes keep the word on the lines for the whole pulse
  wr_strobe_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    (st_reg.mode == 3'h3 && st_reg.state == DIOH_WR_STROBE) |-> st_reg.drive && st_reg.ctl_lvl)
    else $error("mode 3 write strobe without data");
  wr_dir_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    st_reg.state == DIOH_WR_SETUP |-> !st_reg.dir_lvl)
    else $error("direction not low during write setup");
  sequence rd_release_done_s;
    st_reg.state == DIOH_RD_RELEASE && st_reg.cnt == '0
      && (st_reg.mode == 3'h1 || st_reg.mode == 3'h3);
  endsequence
  rd_release_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    rd_release_done_s |=> !st_reg.drive && st_reg.dir_lvl)
    else $error("read did not release the lines");
  sequence rd_latch_done_s;
    st_reg.state == DIOH_RD_LATCH && st_reg.cnt == '0;
  endsequence
  rd_latch_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    rd_latch_done_s |=> st_reg.rvalid)
    else $error("read data not latched");
  // Modes 2 and 4 give no direction change on a read
  rd_dir_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    ((st_reg.mode == 3'h2 || st_reg.mode == 3'h4) && st_reg.state == DIOH_RD_RELEASE)
    |=> $stable(st_reg.dir_lvl)) else $error("direction moved on a read");
  split_rd_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    (st_reg.mode == 3'h4
      && (st_reg.state == DIOH_RD_RELEASE || st_reg.state == DIOH_RD_LATCH))
    |-> st_reg.ctl_lvl) else $error("mode 4 read not marked on control");
  // A strobe that stays up would look like an endless transfer to the peripheral
  strobe_idle_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    (st_reg.mode == 3'h3 && st_reg.state == DIOH_IDLE) |-> !st_reg.ctl_lvl)
    else $error("mode 3 strobe left high");
endmodule : dioh_port

//--- dioh_periph_model.sv
// Peripheral model on the far side of the module port: drives pins, captures words.
// Assumes the port's clock and positive strobe sense while it captures.
`timescale 1ns/1ps
module dioh_periph_model (
  input wire logic clk_in,
  input wire logic [31:0] data_in,
  input wire logic [31:0] oe_in,
  input wire logic dir_in,
  input wire logic strobe_in,
  input wire logic [31:0] pattern_in,
  output logic [31:0] pins_out,
  output logic [31:0] captured_out
);
  logic prev_dir_reg;
  logic prev_strobe_reg;
  // Bits the port leaves undriven carry the peripheral's own pattern, never a stale copy
  assign pins_out = (oe_in & data_in) | (~oe_in & pattern_in);
  // Capture at the trailing edge, while the port still holds the data valid
  always_ff @(posedge clk_in)
  begin
    prev_dir_reg <= dir_in;
    prev_strobe_reg <= strobe_in;
    if ((prev_strobe_reg && !strobe_in) || (prev_dir_reg && !dir_in))
    begin
      captured_out <= pins_out;
    end
  end
endmodule : dioh_periph_model

//--- dioh_port_tb_top.sv
// Testbench for the port controller: registers, modes 1 to 4, FIFO, built-in port.
// Assumes the peripheral model on the module port and a 40 MHz clock.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; $display("FAIL %0t got %h exp %h", $time, a, b); end end
`define WAITC(c, lim) n = 0; while (!(c) && n < lim) begin @(negedge clk); n++; end
module dioh_port_tb_top
  import dioh_pkg::*;
;
  // Short setup count keeps the run brief
  localparam int WS = 50;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata, dout, doe, pins, cap;
  logic [31:0] pat = 32'h0;
  logic dirl, stb, scan_ok;
  logic [3:0] bin = 4'h3;
  logic [3:0] bout, boe;
  logic [63:0] q[$];
  logic rd_pend = 1'b0;
  logic [31:0] x = 32'h4B;
  logic [31:0] w [0:8];
  int n_fail = 0;
  int checks = 0;
  int n;

  dioh_port #(.WR_SETUP_CYCLES(WS), .FIFO_DEPTH(8)) u_dioh_port (
    .CORE_CLK_IN(clk), .RESETN_IN(resetn), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .DATA_IN(pins), .DATA_OUT(dout),
    .DATA_OE_OUT(doe), .DIR_LINE_OUT(dirl), .PERIPHERAL_STROBE_LINE_OUT(stb),
    .PERIPHERAL_FLAG_LINE_IN(1'b0), .BUILTIN_IN(bin), .BUILTIN_OUT(bout),
    .BUILTIN_OE_OUT(boe), .SCAN_OK_OUT(scan_ok));

  dioh_periph_model u_dioh_periph_model (
    .clk_in(clk), .data_in(dout), .oe_in(doe), .dir_in(dirl), .strobe_in(stb),
    .pattern_in(pat), .pins_out(pins), .captured_out(cap));

  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : rnd

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Notes the expected value and mask; the monitor compares when data stands
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    q.push_back({e, m});
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask : cyc

  task automatic stop_test();
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  always @(negedge clk)
  begin
    if (rd_pend)
    begin
      `CHK(rdata & q[0][31:0], q[0][63:32])
      void'(q.pop_front());
    end
    rd_pend = rd;
  end

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    #(60000 * 25);
    n_fail++;
    stop_test();
  end

  initial
  begin
    pat = rnd();
    for (int i = 0; i < 9; i++) w[i] = rnd();
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd_reg(ADDR_MODE, 32'h1, 32'h7);
    rd_reg(ADDR_POL, 32'h0, 32'hF);
    rd_reg(4'hF, 32'h0, 32'hFFFFFFFF);
    // Every mode code, then an illegal code that must leave mode 5 in place
    for (int m = 1; m < 7; m++)
    begin
      wr_reg(ADDR_MODE, m);
      cyc(2);
      `CHK(scan_ok, 1'(m < 3))
      rd_reg(ADDR_MODE, (m == 6) ? 5 : m, 32'h7);
    end
    wr_reg(ADDR_BDIR, 32'h0F);
    wr_reg(ADDR_BUILTIN, 32'h9);
    cyc(2);
    `CHK({boe, bout}, 8'hF9)
    wr_reg(ADDR_BDIR, 32'hA0);
    cyc(4);
    `CHK(boe, 4'h0)
    rd_reg(ADDR_BUILTIN, 32'h9, 32'hF);
    // Fill the FIFO past full while no byte is an output, then drain in mode 1
    wr_reg(ADDR_MODE, 32'h1);
    for (int i = 0; i < 9; i++) wr_reg(ADDR_WDATA, w[i]);
    rd_reg(ADDR_STATUS, 32'h4, 32'h4);
    wr_reg(ADDR_DIR, 32'hF);
    `WAITC(!dirl, 20)
    `WAITC(doe == 32'hFFFFFFFF, 200)
    `CHK(n inside {[WS - 1:WS + 1]}, 1'b1)
    cyc(8 * (WS + 100));
    `CHK(dout, w[7])
    rd_reg(ADDR_STATUS, 32'h0, 32'h5);
    wr_reg(ADDR_CMD, 32'h2);
    `WAITC(dirl, 4100)
    `CHK(n inside {[3997:4002]}, 1'b1)
    `CHK(doe, 32'h0)
    cyc(5980);
    rd_reg(ADDR_STATUS, 32'h0, 32'h8);
    cyc(40);
    rd_reg(ADDR_STATUS, 32'h8, 32'h8);
    rd_reg(ADDR_RDATA, pat, 32'hFFFFFFFF);
    // Mode 2 with mixed byte directions: readback mixes written and pin bytes
    wr_reg(ADDR_MODE, 32'h2);
    wr_reg(ADDR_DIR, 32'h5);
    wr_reg(ADDR_WDATA, w[0]);
    `WAITC(doe == 32'h00FF00FF, 200)
    `CHK(doe, 32'h00FF00FF)
    wr_reg(ADDR_CMD, 32'h2);
    n = 0;
    repeat (10100)
    begin
      @(negedge clk);
      n += int'(dirl);
    end
    `CHK(n, 0)
    `CHK(doe, 32'h00FF00FF)
    rd_reg(ADDR_RDATA, (w[0] & 32'h00FF00FF) | (pat & 32'hFF00FF00), 32'hFFFFFFFF);
    wr_reg(ADDR_MODE, 32'h3);
    wr_reg(ADDR_DIR, 32'hF);
    wr_reg(ADDR_WDATA, w[1]);
    `WAITC(stb, 300)
    `CHK(dirl, 1'b0)
    `WAITC(!stb, 100)
    `CHK(n, STROBE_CYC + 1)
    cyc(2);
    `CHK(cap, w[1])
    wr_reg(ADDR_MODE, 32'h4);
    wr_reg(ADDR_WDATA, w[2]);
    `WAITC(dirl, 50)
    `WAITC(!dirl, 100)
    `CHK(n, STROBE_CYC + 1)
    cyc(2);
    `CHK(cap, w[2])
    wr_reg(ADDR_CMD, 32'h2);
    cyc(100);
    `CHK(stb, 1'b1)
    cyc(10000);
    `CHK(stb, 1'b0)
    rd_reg(ADDR_RDATA, pat, 32'hFFFFFFFF);
    // Mode 3 read with inverted control and data lines
    wr_reg(ADDR_MODE, 32'h3);
    wr_reg(ADDR_POL, 32'h9);
    cyc(2);
    `CHK(stb, 1'b1)
    wr_reg(ADDR_CMD, 32'h2);
    n = 0;
    repeat (10100)
    begin
      @(negedge clk);
      n += int'(!stb);
    end
    `CHK(n > 0 && n < 100, 1'b1)
    rd_reg(ADDR_RDATA, ~pat, 32'hFFFFFFFF);
    // Reset in mid-run must restore defaults and release the port
    @(posedge clk);
    resetn <= 1'b0;
    cyc(3);
    `CHK({doe, dirl, stb}, {32'h0, 2'b10})
    @(posedge clk);
    resetn <= 1'b1;
    rd_reg(ADDR_MODE, 32'h1, 32'h7);
    rd_reg(ADDR_POL, 32'h0, 32'hF);
    cyc(3);
    stop_test();
  end
endmodule : dioh_port_tb_top
